/* File: inc/wdt_pkg.sv */
// Shared constants, types and register map of the watchdog and reset-source unit.
package wdt_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCL_NS        = CLK_PERIOD_NS / 2;
  localparam int RST_MIN_TCL   = 4;
  localparam int SHORT_MAX_TCL = 1038;
  localparam int LONG_MIN_TCL  = 1040;
  localparam int SEQ_TCL       = 1024;
  localparam int MIN_LOW_CYC   = (RST_MIN_TCL * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_MAX_CYC = (SHORT_MAX_TCL * TCL_NS) / CLK_PERIOD_NS;
  localparam int LONG_MIN_CYC  = (LONG_MIN_TCL * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_CYC       = (SEQ_TCL * TCL_NS) / CLK_PERIOD_NS;

  localparam int LOW_W = 11;
  localparam int SEQ_W = 10;
  localparam logic [LOW_W-1:0] LOW_DETECT    = LOW_W'(MIN_LOW_CYC - 1);
  localparam logic [LOW_W-1:0] LOW_SHORT_MAX = LOW_W'(SHORT_MAX_CYC);
  localparam logic [LOW_W-1:0] LOW_SAT       = 11'h7FF;
  localparam logic [SEQ_W-1:0] SEQ_LAST      = SEQ_W'(SEQ_CYC - 1);

  localparam int PRESC_W  = 7;
  localparam int DIV_FAST = 2;
  localparam int DIV_SLOW = 128;
  localparam logic [PRESC_W-1:0] PRESC_FAST_LAST = PRESC_W'(DIV_FAST - 1);
  localparam logic [PRESC_W-1:0] PRESC_SLOW_LAST = PRESC_W'(DIV_SLOW - 1);

  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 16;
  localparam int CNT_W    = 16;
  localparam int RELOAD_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR     = 16'hFFAE;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 16'hFFB0;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 16'hFFB2;
  localparam int PRESC_BIT  = 0;
  localparam int FLAG_LSB   = 1;
  localparam int FLAG_W     = 5;
  localparam int RELOAD_LSB = 8;
  localparam logic [RELOAD_W-1:0] RELOAD_RESET = 8'h00;
  localparam logic                PRESC_RESET  = 1'h0;
  localparam logic [CNT_W-1:0]    CNT_MAX      = 16'hFFFF;
  localparam logic [7:0]          LOW_BYTE_CLR = 8'h00;

  localparam int EV_W               = 3;
  localparam int EV_OVERFLOW        = 0;
  localparam int EV_RESET_DONE      = 1;
  localparam int EV_DISABLE_REFUSED = 2;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;

  typedef struct packed {
    logic pon;
    logic long_hw;
    logic short_hw;
    logic sw;
    logic ovf;
  } reset_flags_t;

  typedef struct packed {
    logic [RELOAD_W-1:0] reload;
    logic                presc_sel;
  } wdt_ctrl_t;

  typedef enum logic [1:0] {ST_RUN, ST_SEQ, ST_SAMPLE, ST_EXTEND} state_t;
  typedef enum logic [1:0] {SRC_PIN, SRC_SW, SRC_WDT} src_t;
endpackage

/* File: verilog/reset_pin_meter.sv */
// Measures consecutive low cycles on the reset input and flags a valid reset pulse.
`timescale 1ns/10ps
`default_nettype none
module reset_pin_meter
  import wdt_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_pin,
  output logic                  o_detect,
  output logic      [LOW_W-1:0] o_low_cycles
);
  logic             pin_d_reg;
  logic [LOW_W-1:0] low_cnt_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      pin_d_reg <= 1'h1;
    end
    else
    begin
      pin_d_reg <= i_pin;
    end
  end

  // The count holds after the pin rises so the owner can classify the pulse.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      low_cnt_reg <= '0;
    end
    else if (!i_pin)
    begin
      if (pin_d_reg)
      begin
        low_cnt_reg <= 11'h001;
      end
      else if (low_cnt_reg != LOW_SAT)
      begin
        low_cnt_reg <= low_cnt_reg + 11'h001;
      end
    end
  end

  assign o_detect     = !i_pin && !pin_d_reg && (low_cnt_reg == LOW_DETECT);
  assign o_low_cycles = low_cnt_reg;
endmodule // reset_pin_meter
`default_nettype wire

/* File: verilog/watchdog_reset_source_unit.sv */
// Watchdog timer, internal reset sequencer and reset-source indication flags.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (RULE1) Watchdog runs after reset; disable only before init.
// (RULE2) Overflow forces internal reset, reset output low.
// (RULE3) Prescale bit picks clock divide 2 or 128.
// (RULE4) Overflow flag set on overflow, hardware/service clear.
// (RULE5) Software reset flag cleared only by end-of-init.
// (RULE6) Short pin pulse sets short flag.
// (RULE7) Pin low over 1040 half-periods sets long.
// (RULE8) Power-on detect sets power-on flag.
// (RULE9) Software writes never change reset flags.
// (RULE10) Flags accumulate; end-of-init clears them all.
// (RULE11) Each reset source sets its own flag set.
// (RULE12) Bidirectional pin held low makes reset long.
// (RULE13) Sixteen-bit counter, high byte from reload field.
// (RULE14) Service reloads high byte from reload field.
// (RULE15) Software should rewrite control before servicing.
// (RULE16) Timeout is 512*(1+63*sel)*(256-reload) cycles.
// (RULE17) Software must service before overflow.
// (RULE18) Counter counts up; service clears low byte.
// (RULE19) Reload and prescale select clear on reset.
module watchdog_reset_source_unit
  import wdt_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_wr_stb,
  input  wire logic              i_rd_stb,
  output logic      [DATA_W-1:0] o_rd_data,
  input  wire logic              i_service_instr,
  input  wire logic              i_end_of_init_instr,
  input  wire logic              i_software_reset_instr,
  input  wire logic              i_disable_instr,
  input  wire logic              i_bidir_reset_en,
  input  wire logic              i_power_on_detect,
  input  wire logic              i_reset_input_pin,
  output logic                   o_reset_input_pin,
  output logic                   o_reset_input_pin_oe_n,
  output logic                   o_reset_output_pin_n,
  output logic                   o_chip_reset,
  output logic                   o_irq
);
  state_t             state_reg;
  src_t               src_reg;
  logic               long_reg;
  logic               pon_reg;
  logic               bidir_reg;
  reset_flags_t       flags_reg;
  reset_flags_t       flags_next;
  wdt_ctrl_t          ctrl_reg;
  logic               wdt_en_reg;
  logic               init_done_reg;
  logic [PRESC_W-1:0] presc_cnt_reg;
  logic [CNT_W-1:0]   cnt_reg;
  logic [SEQ_W-1:0]   seq_cnt_reg;
  logic [EV_W-1:0]    irq_stat_reg;
  logic [EV_W-1:0]    irq_mask_reg;
  logic [EV_W-1:0]    events;
  logic [LOW_W-1:0]   low_cycles;
  logic               pin_detect;
  logic               running;
  logic               tick;
  logic               overflow;
  logic               sw_req;
  logic               pin_req;
  logic               start_rst;
  logic               seq_done;
  logic               apply;
  logic               long_now;
  logic               ctrl_wr;

  function automatic logic [PRESC_W-1:0] presc_last(input logic sel);
    return sel ? PRESC_SLOW_LAST : PRESC_FAST_LAST;
  endfunction

  function automatic reset_flags_t flags_for(input src_t s, input logic lng, input logic pon);
    reset_flags_t f;
    f = '0;
    f.sw = 1'h1;
    if (pon)
    begin
      f.pon      = 1'h1;
      f.long_hw  = 1'h1;
      f.short_hw = 1'h1;
    end
    else if (lng)
    begin
      f.long_hw  = 1'h1;
      f.short_hw = 1'h1;
    end
    else if (s == SRC_PIN)
    begin
      f.short_hw = 1'h1;
    end
    else if (s == SRC_WDT)
    begin
      f.ovf = 1'h1;
    end
    return f;
  endfunction

  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a == b;
  endfunction

  reset_pin_meter u_meter (
    .i_sys_clk    (i_sys_clk),
    .i_rst        (i_rst),
    .i_pin        (i_reset_input_pin),
    .o_detect     (pin_detect),
    .o_low_cycles (low_cycles)
  );

  assign running   = (state_reg == ST_RUN);
  assign ctrl_wr   = i_wr_stb && is_addr(i_addr, CTRL_ADDR) && running;
  assign tick      = running && wdt_en_reg
                     && (presc_cnt_reg == presc_last(ctrl_reg.presc_sel)); // [RULE3]
  assign overflow  = tick && (cnt_reg == CNT_MAX) && !i_service_instr; // [RULE2] [RULE18]
  assign sw_req    = running && i_software_reset_instr;
  assign pin_req   = running && (pin_detect || i_power_on_detect); // [RULE6] [RULE8]
  assign start_rst = overflow || sw_req || pin_req;
  assign seq_done  = (state_reg == ST_SEQ) && (seq_cnt_reg == SEQ_LAST);
  assign apply     = ((state_reg == ST_SAMPLE) || (state_reg == ST_EXTEND)) && i_reset_input_pin;
  // A pin pulse counts as long once it outlasts the short window.
  assign long_now  = long_reg || ((src_reg == SRC_PIN) && (low_cycles > LOW_SHORT_MAX)); // [RULE7]

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_reg <= ST_RUN;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          if (start_rst)
          begin
            state_reg <= ST_SEQ; // [RULE2]
          end
        end
        ST_SEQ:
        begin
          if (seq_done)
          begin
            state_reg <= ST_SAMPLE;
          end
        end
        ST_SAMPLE:
        begin
          state_reg <= i_reset_input_pin ? ST_RUN : ST_EXTEND;
        end
        ST_EXTEND:
        begin
          if (i_reset_input_pin)
          begin
            state_reg <= ST_RUN;
          end
        end
        default:
        begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      seq_cnt_reg <= '0;
    end
    else if (state_reg != ST_SEQ)
    begin
      seq_cnt_reg <= '0;
    end
    else
    begin
      seq_cnt_reg <= seq_cnt_reg + 10'h001;
    end
  end

  // The pin source wins a tie because it also reports supply trouble.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      src_reg   <= SRC_PIN;
      long_reg  <= 1'h0;
      pon_reg   <= 1'h0;
      bidir_reg <= 1'h0;
    end
    else if (start_rst)
    begin
      src_reg   <= pin_req ? SRC_PIN : (overflow ? SRC_WDT : SRC_SW); // [RULE11]
      long_reg  <= 1'h0;
      pon_reg   <= i_power_on_detect; // [RULE8]
      bidir_reg <= i_bidir_reset_en;
    end
    else if (!running)
    begin
      if ((state_reg == ST_SAMPLE) && !i_reset_input_pin && bidir_reg)
      begin
        long_reg <= 1'h1; // [RULE12]
      end
      if (i_power_on_detect)
      begin
        pon_reg <= 1'h1;
      end
    end
  end

  always_comb
  begin
    flags_next = flags_reg;
    if (apply)
    begin
      if ((src_reg == SRC_PIN) || long_now || pon_reg)
      begin
        flags_next.ovf = 1'h0; // [RULE4]
      end
      flags_next = flags_next | flags_for(src_reg, long_now, pon_reg); // [RULE11] [RULE12]
    end
    else if (running && i_end_of_init_instr)
    begin
      flags_next = '0; // [RULE5] [RULE10]
    end
    else if (running && i_service_instr)
    begin
      flags_next.ovf = 1'h0; // [RULE4]
    end
  end

  // Bus writes never reach the flags; only the next-value logic does.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      flags_reg <= '0;
    end
    else
    begin
      flags_reg <= flags_next; // [RULE9]
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !running)
    begin
      ctrl_reg.reload    <= RELOAD_RESET; // [RULE19]
      ctrl_reg.presc_sel <= PRESC_RESET;
    end
    else if (ctrl_wr)
    begin
      ctrl_reg.reload    <= i_wr_data[RELOAD_LSB +: RELOAD_W];
      ctrl_reg.presc_sel <= i_wr_data[PRESC_BIT];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !running)
    begin
      wdt_en_reg    <= 1'h1; // [RULE1]
      init_done_reg <= 1'h0;
    end
    else
    begin
      if (i_end_of_init_instr)
      begin
        init_done_reg <= 1'h1;
      end
      if (i_disable_instr && !init_done_reg)
      begin
        wdt_en_reg <= 1'h0; // [RULE1]
      end
    end
  end

  // Counter and prescaler stay cleared while any reset sequence runs.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !running)
    begin
      presc_cnt_reg <= '0;
      cnt_reg       <= '0;
    end
    else if (i_service_instr)
    begin
      presc_cnt_reg <= '0;
      cnt_reg       <= {ctrl_reg.reload, LOW_BYTE_CLR}; // [RULE13] [RULE14] [RULE18]
    end
    else if (tick)
    begin
      presc_cnt_reg <= '0;
      cnt_reg       <= cnt_reg + 16'h0001; // [RULE16] [RULE18]
    end
    else if (wdt_en_reg)
    begin
      presc_cnt_reg <= presc_cnt_reg + 7'h01;
    end
  end

  assign events[EV_OVERFLOW]        = overflow;
  assign events[EV_RESET_DONE]      = apply;
  assign events[EV_DISABLE_REFUSED] = running && i_disable_instr && init_done_reg;

  // A read clears the status, but an event in the same cycle survives.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      irq_stat_reg <= '0;
    end
    else if (i_rd_stb && is_addr(i_addr, IRQ_STAT_ADDR))
    begin
      irq_stat_reg <= events;
    end
    else
    begin
      irq_stat_reg <= irq_stat_reg | events;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      irq_mask_reg <= IRQ_MASK_RESET;
    end
    else if (i_wr_stb && is_addr(i_addr, IRQ_MASK_ADDR))
    begin
      irq_mask_reg <= i_wr_data[EV_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_rd_data <= '0;
    end
    else
    begin
      o_rd_data <= '0;
      if (i_rd_stb)
      begin
        if (is_addr(i_addr, CTRL_ADDR))
        begin
          o_rd_data[RELOAD_LSB +: RELOAD_W] <= ctrl_reg.reload;
          o_rd_data[FLAG_LSB +: FLAG_W]     <= flags_reg;
          o_rd_data[PRESC_BIT]              <= ctrl_reg.presc_sel;
        end
        else if (is_addr(i_addr, IRQ_STAT_ADDR))
        begin
          o_rd_data[EV_W-1:0] <= irq_stat_reg;
        end
        else if (is_addr(i_addr, IRQ_MASK_ADDR))
        begin
          o_rd_data[EV_W-1:0] <= irq_mask_reg;
        end
      end
    end
  end

  assign o_irq                  = |(irq_stat_reg & irq_mask_reg);
  assign o_chip_reset           = !running;
  assign o_reset_output_pin_n   = running; // [RULE2]
  assign o_reset_input_pin      = 1'h0;
  assign o_reset_input_pin_oe_n = !((state_reg == ST_SEQ) && bidir_reg); // [RULE12]

  property p_overflow_reset;
    @(posedge i_sys_clk) disable iff (i_rst)
    overflow |=> (state_reg == ST_SEQ) && !o_reset_output_pin_n && o_chip_reset;
  endproperty
  a_overflow_reset: assert property (p_overflow_reset) else $error("overflow gave no reset"); // [RULE2]

  property p_tick_div;
    @(posedge i_sys_clk) disable iff (i_rst)
    tick |-> presc_cnt_reg == (ctrl_reg.presc_sel ? 7'h7F : 7'h01);
  endproperty
  a_tick_div: assert property (p_tick_div) else $error("prescaler tick at wrong count"); // [RULE3]

  property p_service_reload;
    @(posedge i_sys_clk) disable iff (i_rst)
    (running && i_service_instr) |=> cnt_reg == {$past(ctrl_reg.reload), 8'h00};
  endproperty
  a_service_reload: assert property (p_service_reload) else $error("service reload wrong"); // [RULE14]

  property p_write_keeps_flags;
    @(posedge i_sys_clk) disable iff (i_rst)
    (ctrl_wr && !i_end_of_init_instr && !i_service_instr) |=> flags_reg == $past(flags_reg);
  endproperty
  a_write_keeps_flags: assert property (p_write_keeps_flags) else $error("write changed flags"); // [RULE9]

  property p_end_of_init_instr_clears;
    @(posedge i_sys_clk) disable iff (i_rst)
    (running && i_end_of_init_instr) |=> flags_reg == '0;
  endproperty
  a_end_of_init_instr_clears: assert property (p_end_of_init_instr_clears) else $error("end of init left flags"); // [RULE10]

  property p_reset_restores;
    @(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_chip_reset) |-> wdt_en_reg && !init_done_reg && (ctrl_reg == '0);
  endproperty
  a_reset_restores: assert property (p_reset_restores) else $error("reset state not restored"); // [RULE1]

  property p_late_disable;
    @(posedge i_sys_clk) disable iff (i_rst)
    (running && init_done_reg && wdt_en_reg && i_disable_instr) |=> wdt_en_reg;
  endproperty
  a_late_disable: assert property (p_late_disable) else $error("late disable accepted"); // [RULE1]

  property p_wdt_flags;
    @(posedge i_sys_clk) disable iff (i_rst)
    (apply && (src_reg == SRC_WDT) && !long_now && !pon_reg) |=> flags_reg.sw && flags_reg.ovf;
  endproperty
  a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog reset flags wrong"); // [RULE11]

  property p_sw_reset_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
    (sw_req && !pin_req && !overflow) |=> o_chip_reset [*8];
  endproperty
  a_sw_reset_hold: assert property (p_sw_reset_hold) else $error("software reset too short"); // [RULE5]

  property p_bidir_long;
    @(posedge i_sys_clk) disable iff (i_rst)
    ((state_reg == ST_SAMPLE) && !i_reset_input_pin && bidir_reg) |=> long_reg;
  endproperty
  a_bidir_long: assert property (p_bidir_long) else $error("bidirectional reset not long"); // [RULE12]
endmodule // watchdog_reset_source_unit
`default_nettype wire

/* File: testbench/watchdog_reset_source_unit_tb_top.sv */
// Self-checking testbench of the watchdog and reset-source unit.
`timescale 1ns/10ps
`default_nettype none
module watchdog_reset_source_unit_tb_top
  import wdt_pkg::*;
;
  localparam int SVC = 0;
  localparam int EOI = 1;
  localparam int SRS = 2;
  localparam int DIS = 3;

  logic              i_sys_clk         = 1'b0;
  logic              i_rst             = 1'b1;
  logic [ADDR_W-1:0] i_addr            = 16'h0000;
  logic [DATA_W-1:0] i_wr_data         = 16'h0000;
  logic              i_wr_stb          = 1'b0;
  logic              i_rd_stb          = 1'b0;
  logic [3:0]        instr             = 4'h0;
  logic              i_bidir_reset_en  = 1'b0;
  logic              i_power_on_detect = 1'b0;
  logic              pin_drv           = 1'b1;
  wire logic         i_reset_input_pin;
  logic [DATA_W-1:0] o_rd_data;
  logic              pin_val;
  logic              oe_n;
  logic              rst_out_n;
  logic              o_chip_reset;
  logic              o_irq;
  logic [DATA_W-1:0] exp_q[$];
  logic              rd_seen           = 1'b0;
  logic [DATA_W-1:0] exp_pin[3]        = '{16'h000C, 16'h001C, 16'h003C};
  logic [DATA_W-1:0] r;
  logic [7:0]        rl;
  logic              p;
  int                n_errors          = 0;
  int                checks_done       = 0;
  int                n;
  int                e;

  // The pin has a pull-up, so the bench drives high unless it pulls the line low itself.
  assign i_reset_input_pin = oe_n ? pin_drv : pin_val;

  watchdog_reset_source_unit dut_u (
    .i_sys_clk              (i_sys_clk),
    .i_rst                  (i_rst),
    .i_addr                 (i_addr),
    .i_wr_data              (i_wr_data),
    .i_wr_stb               (i_wr_stb),
    .i_rd_stb               (i_rd_stb),
    .o_rd_data              (o_rd_data),
    .i_service_instr        (instr[SVC]),
    .i_end_of_init_instr    (instr[EOI]),
    .i_software_reset_instr (instr[SRS]),
    .i_disable_instr        (instr[DIS]),
    .i_bidir_reset_en       (i_bidir_reset_en),
    .i_power_on_detect      (i_power_on_detect),
    .i_reset_input_pin      (i_reset_input_pin),
    .o_reset_input_pin      (pin_val),
    .o_reset_input_pin_oe_n (oe_n),
    .o_reset_output_pin_n   (rst_out_n),
    .o_chip_reset           (o_chip_reset),
    .o_irq                  (o_irq)
  );

  initial
  begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [DATA_W-1:0] ex, input logic [DATA_W-1:0] got);
    checks_done++;
    if (got !== ex)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at that edge.
  always @(posedge i_sys_clk)
  begin
    if (rd_seen)
      chk("rd_data", exp_q.pop_front(), o_rd_data);
    rd_seen <= i_rd_stb;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
    tick(1);
    i_wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
    exp_q.push_back(ex);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    tick(1);
    i_rd_stb <= 1'b0;
    tick(1);
  endtask

  task automatic pulse(input int k);
    instr[k] <= 1'b1;
    tick(1);
    instr <= 4'h0;
  endtask

  // Bounded waits, so a reset that never comes or never ends shows as a mismatch.
  task automatic wait_rst();
    n = 0;
    while (o_chip_reset !== 1'b1 && n < 40000)
    begin
      tick(1);
      n++;
    end
    chk("chip_reset_rise", 16'h0001, {15'h0, o_chip_reset});
    chk("reset_out_n", 16'h0000, {15'h0, rst_out_n});
    repeat (2000) if (o_chip_reset === 1'b1) tick(1);
    chk("chip_reset_fall", 16'h0000, {15'h0, o_chip_reset});
    tick(2);
  endtask

  initial
  begin
    repeat (100000) @(posedge i_sys_clk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    r = $urandom(32'h55fc0d3a);
    tick(6);
    i_rst <= 1'b0;
    tick(2);
    rd(CTRL_ADDR, 16'h0000);
    rd(IRQ_MASK_ADDR, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      wr(CTRL_ADDR, r);
      rd(CTRL_ADDR, {r[15:8], 7'h00, r[0]});
      wr({4'h1, r[11:0]}, r);
      rd({4'h1, r[11:0]}, 16'h0000);
    end
    pulse(DIS);
    wr(CTRL_ADDR, 16'hFF00);
    pulse(SVC);
    tick(700);
    chk("chip_reset", 16'h0000, {15'h0, o_chip_reset});
    pulse(SRS);
    wait_rst();
    rd(CTRL_ADDR, 16'h0004);
    wr(IRQ_MASK_ADDR, 16'h0007);
    chk("irq", 16'h0001, {15'h0, o_irq});
    rd(IRQ_STAT_ADDR, 16'h0002);
    chk("irq", 16'h0000, {15'h0, o_irq});
    pulse(EOI);
    rd(CTRL_ADDR, 16'h0000);
    pulse(DIS);
    chk("irq", 16'h0001, {15'h0, o_irq});
    rd(IRQ_STAT_ADDR, 16'h0004);
    wr(CTRL_ADDR, 16'hFF00);
    for (int i = 0; i < 3; i++)
    begin
      pulse(SVC);
      tick(400);
    end
    chk("chip_reset", 16'h0000, {15'h0, o_chip_reset});
    // Two fast-prescale timeouts (reload FF and FE) and one slow one with reload FF keep the run brief.
    for (int t = 0; t < 3; t++)
    begin
      rl = (t == 1) ? 8'hFE : 8'hFF;
      p = (t == 2);
      wr(CTRL_ADDR, {rl, 7'h00, p});
      pulse(SVC);
      wait_rst();
      e = 512 * (1 + 63 * p) * (256 - rl);
      chk("timeout_cycles", 16'(e), 16'((n >= e - 3 && n <= e + 3) ? e : n));
      rd(CTRL_ADDR, 16'h0006);
    end
    pulse(SVC);
    rd(CTRL_ADDR, 16'h0004);
    for (int k = 0; k < 3; k++)
    begin
      pulse(EOI);
      if (k == 2)
        i_power_on_detect <= 1'b1;
      else
        pin_drv <= 1'b0;
      tick(k == 0 ? 10 : (k == 1 ? 600 : 3));
      i_power_on_detect <= 1'b0;
      pin_drv <= 1'b1;
      wait_rst();
      rd(CTRL_ADDR, exp_pin[k]);
    end
    pulse(EOI);
    i_bidir_reset_en <= 1'b1;
    pulse(SRS);
    tick(5);
    chk("pin_oe_n", 16'h0000, {15'h0, oe_n});
    pin_drv <= 1'b0;
    tick(600);
    pin_drv <= 1'b1;
    wait_rst();
    rd(CTRL_ADDR, 16'h001C);
    report_and_stop();
  end
endmodule // watchdog_reset_source_unit_tb_top
`default_nettype wire
